// ==== dv/scsd_partner.sv ====
/*
 remote serial transceiver: sends frames on rxd, reports bytes seen on txd.
 assumes bit time BT clock cycles and frame start, 8 data lsb first, mp, stop.
*/
`timescale 1ns/1ps
module scsd_partner #(
  parameter int BT = 16
) (
  // clock
  input wire logic clk,
  // serial lines
  input wire logic txd,
  output logic rxd,
  // received byte report
  output logic got_stb,
  output logic [7:0] got_byte
);
  // ==========================================================
  logic [7:0] sh; // receive shifter
  initial begin
    rxd = 1'b1;
    got_stb = 1'b0;
    got_byte = 8'h00;
  end
  // one frame; a stop of 0 makes a framing fault on purpose
  task automatic send(input logic [7:0] d, input logic mp, input logic stop);
    logic [10:0] fr;
    fr = {stop, mp, d, 1'b0};
    for (int i = 0; i < 11; i++) begin
      @(posedge clk);
      rxd <= fr[i];
      repeat (BT - 1) @(posedge clk);
    end
    @(posedge clk);
    rxd <= 1'b1;
    repeat (BT) @(posedge clk);
  endtask
  // plain level on the line, for general input use of the pin
  task automatic line(input logic v);
    @(posedge clk);
    rxd <= v;
  endtask
  // a low shorter than half a bit is not a start, so aborts are ignored
  initial forever begin
    @(posedge clk);
    if (txd === 1'b0) begin
      repeat (BT / 2) @(posedge clk);
      if (txd === 1'b0) begin
        for (int i = 0; i < 8; i++) begin
          repeat (BT) @(posedge clk);
          sh[i] = txd;
        end
        repeat (2 * BT) @(posedge clk);
        if (txd === 1'b1) begin
          got_byte <= sh;
          got_stb <= 1'b1;
          @(posedge clk);
          got_stb <= 1'b0;
        end
      end
    end
  end
endmodule

// ==== dv/scsd_top_asserts.sv ====
/*
 checker for the serial channel top: bus answer, pin muxing and frame timing.
 assumes it is bound to scsd_top and that frames are timed at bit rate setting 0.
*/
`timescale 1ns/1ps
module scsd_top_asserts (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // ahb-lite
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [31:0] hrdata,
  input wire logic hreadyout,
  input wire logic hresp,
  // pins and interrupt
  input wire logic txd,
  input wire logic txd_oe,
  input wire logic txd_gpio_out,
  input wire logic irq
);
  // ==========================================================
  // shadow of the writable registers the checks depend on
  logic ap_q;
  logic [7:0] idx_q;
  logic [7:0] ctl_q;
  logic [7:0] brr_q;
  logic [3:0] en_q;
  logic [7:0] fc_q; // position inside a transmitted frame
  logic [7:0] fc_d;
  logic rd_ap;
  assign rd_ap = hsel && hready && htrans[1] && !hwrite;
  // frame position only counted at the fast rate, so bit times are fixed
  always_comb begin
    fc_d = 8'h00;
    if (ctl_q[5] && brr_q == 8'h00) begin
      if (fc_q != 8'h00) begin
        fc_d = (fc_q == 8'haf) ? 8'h00 : fc_q + 8'h01;
      end else if (!txd) begin
        fc_d = 8'h01;
      end
    end
  end
  // writes land at the data-phase edge, as in the design
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      ap_q <= 1'b0;
      idx_q <= 8'h00;
      ctl_q <= 8'h00;
      brr_q <= 8'hff;
      en_q <= 4'h0;
      fc_q <= 8'h00;
    end else begin
      ap_q <= hsel && hready && htrans[1] && hwrite;
      idx_q <= haddr[9:2];
      if (ap_q && idx_q == scsd_pkg::IDX_CONTROL) ctl_q <= hwdata[7:0];
      if (ap_q && idx_q == scsd_pkg::IDX_BIT_RATE) brr_q <= hwdata[7:0];
      if (ap_q && idx_q == scsd_pkg::IDX_IRQ_EN) en_q <= hwdata[3:0];
      fc_q <= fc_d;
    end
  end
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_n);
  // ==========================================================
  // named steps
  sequence s_unmapped_rd;
    rd_ap && haddr[9:2] == 8'hb3;
  endsequence
  sequence s_stop;
    txd[*8] ##1 txd[*8];
  endsequence
  a_resp_okay: assert property (hresp == 1'b0 && hreadyout == 1'b1)
    else $error("bus answer not okay and ready");
  a_oe_high: assert property (txd_oe == 1'b1)
    else $error("txd output enable low");
  a_gpio_mux: assert property (!ctl_q[5] |-> txd == txd_gpio_out)
    else $error("txd not general output while tx disabled");
  a_unmapped_zero: assert property (s_unmapped_rd |=> hrdata == 32'h0)
    else $error("unmapped read not zero");
  a_rdata_stands: assert property (!$stable(hrdata) |-> $past(rd_ap))
    else $error("read data changed without read");
  a_start_low: assert property ((ctl_q[5] && fc_q inside {[1:15]}) |-> !txd)
    else $error("start bit too short");
  a_stop_high: assert property ((ctl_q[5] && fc_q == 8'ha0) |-> s_stop)
    else $error("stop bit wrong");
  a_irq_masked: assert property (irq |-> (en_q != 4'h0 || $past(en_q) != 4'h0))
    else $error("interrupt with all events masked");
endmodule
bind scsd_top scsd_top_asserts u_chk (.clk(clk), .rst_n(rst_n), .hsel(hsel),
  .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hwdata(hwdata), .hready(hready),
  .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .txd(txd), .txd_oe(txd_oe),
  .txd_gpio_out(txd_gpio_out), .irq(irq));

// ==== dv/serial_channel_status_and_data_tb_top.sv ====
/*
 self-checking bench: ahb-lite master, partner transceiver, queued expectations.
 assumes scsd_top with zero wait states and bit rate setting 0 for frames.
*/
`timescale 1ns/1ps
module serial_channel_status_and_data_tb_top;
  // ==========================================================
  logic clk, rst_n, hsel, hwrite, hreadyout, hresp, rxd, txd, txd_oe;
  logic txd_gpio_out, rxd_gpio_in, irq, dph, got_stb;
  logic [31:0] haddr, hwdata, hrdata, seed, r;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [7:0] b, d, got_byte;
  logic [31:0] exp_q[$], msk_q[$]; // pending read notes
  logic [7:0] ser_q[$]; // bytes the partner should see
  int errors, checked;
  scsd_top DUT (.clk(clk), .rst_n(rst_n), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
    .hrdata(hrdata), .hreadyout(hreadyout), .hresp(hresp), .txd(txd), .txd_oe(txd_oe),
    .rxd(rxd), .txd_gpio_out(txd_gpio_out), .rxd_gpio_in(rxd_gpio_in), .irq(irq));
  scsd_partner #(.BT(16)) part (.clk(clk), .txd(txd), .rxd(rxd), .got_stb(got_stb),
    .got_byte(got_byte));
  initial begin
    clk = 1'b0;
    forever #20 clk = ~clk;
  end
  // ==========================================================
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      errors++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic end_of_test();
    $display("comparisons %0d mismatches %0d", checked, errors);
    if (errors == 0 && checked > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask
  // single transfer; address held until ready, data taken at the second edge
  task automatic bus(input logic w, input logic [7:0] idx, input logic [31:0] wd,
                     input logic note, output logic [31:0] rd);
    hsel <= 1'b1;
    haddr <= {22'h0, idx, 2'b00};
    hwrite <= w;
    htrans <= 2'b10;
    do @(posedge clk); while (hreadyout !== 1'b1);
    htrans <= 2'b00;
    hwdata <= wd;
    dph <= note;
    do @(posedge clk); while (hreadyout !== 1'b1);
    rd = hrdata;
    dph <= 1'b0;
  endtask
  task automatic wr(input logic [7:0] idx, input logic [31:0] wd);
    bus(1'b1, idx, wd, 1'b0, r);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [31:0] exp, input logic [31:0] m);
    exp_q.push_back(exp & m);
    msk_q.push_back(m);
    bus(1'b0, idx, 32'h0, 1'b1, r);
  endtask
  // poll a status bit with a bounded count
  task automatic wait_bit(input int pos);
    for (int i = 0; i < 300 && r[pos] !== 1'b1; i++) bus(1'b0, 8'hac, 32'h0, 1'b0, r);
    if (r[pos] !== 1'b1) check(r, 32'hffffffff);
  endtask
  // observer: oldest note against each result that appears
  always @(posedge clk) begin
    if (dph && hreadyout) check(hrdata & msk_q.pop_front(), exp_q.pop_front());
    if (got_stb) check({24'h0, got_byte}, {24'h0, ser_q.pop_front()});
  end
  initial begin
    #(40 * 20000);
    errors++;
    $display("[FAIL] %0t watchdog expired", $time);
    end_of_test();
  end
  // ==========================================================
  initial begin
    rst_n = 1'b0;
    hsel = 1'b0;
    haddr = 32'h0;
    htrans = 2'b00;
    hwrite = 1'b0;
    hsize = 3'h2;
    hwdata = 32'h0;
    txd_gpio_out = 1'b1;
    dph = 1'b0;
    errors = 0;
    checked = 0;
    r = 32'h0;
    seed = $urandom(17);
    repeat (2) @(posedge clk);
    rst_n <= 1'b1;
    @(posedge clk);
    // reset values, unmapped place, written ones ignored by flags
    rd(scsd_pkg::IDX_BIT_RATE, 32'hff, 32'hff);
    rd(scsd_pkg::IDX_CONTROL, 32'h00, 32'hff);
    rd(scsd_pkg::IDX_TX_DATA, 32'hff, 32'hff);
    rd(scsd_pkg::IDX_RX_DATA, 32'h00, 32'hff);
    wr(8'hb3, 32'hffffffff);
    rd(8'hb3, 32'h0, 32'hffffffff);
    wr(scsd_pkg::IDX_STATUS, 32'hf8);
    rd(scsd_pkg::IDX_STATUS, 32'h84, 32'hff);
    b = 8'($urandom);
    wr(scsd_pkg::IDX_BIT_RATE, {24'h0, b});
    rd(scsd_pkg::IDX_BIT_RATE, {24'h0, b}, 32'hff);
    wr(scsd_pkg::IDX_BIT_RATE, 32'h0);
    wr(scsd_pkg::IDX_IRQ_EN, 32'hf);
    wr(scsd_pkg::IDX_CONTROL, 32'h30);
    // send by data write, then again by clearing the empty flag
    b = 8'($urandom);
    ser_q.push_back(b);
    ser_q.push_back(b);
    wr(scsd_pkg::IDX_TX_DATA, {24'h0, b});
    rd(scsd_pkg::IDX_STATUS, 32'h0, 32'h7f);
    rd(scsd_pkg::IDX_TX_DATA, {24'h0, b}, 32'hff);
    r = 32'h0;
    wait_bit(2);
    rd(scsd_pkg::IDX_STATUS, 32'h84, 32'hff);
    rd(scsd_pkg::IDX_IRQ_STAT, 32'h9, 32'h9);
    wr(scsd_pkg::IDX_STATUS, 32'h7e);
    rd(scsd_pkg::IDX_STATUS, 32'h0, 32'h7f);
    r = 32'h0;
    wait_bit(2);
    // disable just after a data write: end flag set, pin back to general use
    wr(scsd_pkg::IDX_TX_DATA, {24'h0, ~b});
    wr(scsd_pkg::IDX_CONTROL, 32'h10);
    rd(scsd_pkg::IDX_STATUS, 32'h04, 32'h04);
    txd_gpio_out <= 1'b0;
    @(posedge clk);
    check({31'h0, txd}, 32'h0);
    txd_gpio_out <= 1'b1;
    wr(scsd_pkg::IDX_IRQ_CLR, 32'hf);
    // receive with mp bit one, then overrun, framing, mp bit zero
    d = 8'($urandom);
    part.send(d, 1'b1, 1'b1);
    r = 32'h0;
    wait_bit(6);
    rd(scsd_pkg::IDX_STATUS, 32'h42, 32'h42);
    rd(scsd_pkg::IDX_RX_DATA, {24'h0, d}, 32'hff);
    check({31'h0, irq}, 32'h1);
    rd(scsd_pkg::IDX_IRQ_STAT, 32'h2, 32'h2);
    wr(scsd_pkg::IDX_IRQ_EN, 32'h0);
    repeat (2) @(posedge clk);
    check({31'h0, irq}, 32'h0);
    wr(scsd_pkg::IDX_IRQ_CLR, 32'hf);
    rd(scsd_pkg::IDX_IRQ_STAT, 32'h0, 32'h2);
    part.send(d ^ 8'h5a, 1'b0, 1'b1);
    rd(scsd_pkg::IDX_STATUS, 32'h60, 32'h60);
    rd(scsd_pkg::IDX_RX_DATA, {24'h0, d}, 32'hff);
    wr(scsd_pkg::IDX_STATUS, 32'h86);
    rd(scsd_pkg::IDX_STATUS, 32'h0, 32'h78);
    part.send(8'h3c, 1'b0, 1'b0);
    rd(scsd_pkg::IDX_STATUS, 32'h10, 32'h10);
    rd(scsd_pkg::IDX_IRQ_STAT, 32'h4, 32'h4);
    wr(scsd_pkg::IDX_STATUS, 32'h86);
    d = 8'($urandom);
    part.send(d, 1'b0, 1'b1);
    r = 32'h0;
    wait_bit(6);
    rd(scsd_pkg::IDX_STATUS, 32'h40, 32'h52);
    rd(scsd_pkg::IDX_RX_DATA, {24'h0, d}, 32'hff);
    // receiver off: pin read as a plain input
    wr(scsd_pkg::IDX_CONTROL, 32'h0);
    part.line(1'b0);
    repeat (4) @(posedge clk);
    check({31'h0, rxd_gpio_in}, 32'h0);
    part.line(1'b1);
    repeat (4) @(posedge clk);
    check({31'h0, rxd_gpio_in}, 32'h1);
    end_of_test();
  end
endmodule

// ==== verilog/scsd_pkg.sv ====
/*
 serial channel package: register map, field layout, reset values and timing.
 assumes a 32-bit ahb-lite register bus and a 25 MHz system clock.
*/
package scsd_pkg;
  // ==========================================================
  // register map (printed offsets are not multiples of four)
  localparam logic [7:0] IDX_TX_DATA = 8'hab;   // transmit_data index
  localparam logic [7:0] IDX_RX_DATA = 8'had;   // receive_data index
  localparam logic [7:0] IDX_BIT_RATE = 8'ha9;  // bit_rate_setting index
  localparam logic [7:0] IDX_CONTROL = 8'haa;   // serial_control index
  localparam logic [7:0] IDX_STATUS = 8'hac;    // serial_status index
  localparam logic [7:0] IDX_IRQ_STAT = 8'hb0;  // sticky event status
  localparam logic [7:0] IDX_IRQ_EN = 8'hb1;    // event enable
  localparam logic [7:0] IDX_IRQ_CLR = 8'hb2;   // event clear, write only
  // ==========================================================
  // reset values
  localparam logic [7:0] RST_TX_DATA = 8'hff;
  localparam logic [7:0] RST_RX_DATA = 8'h00;
  localparam logic [7:0] RST_BIT_RATE = 8'hff;
  localparam logic [7:0] RST_CONTROL = 8'h00;
  localparam logic [7:0] RST_STATUS = 8'h84;
  // ==========================================================
  // control field positions
  localparam int CTL_TX_EN = 5;
  localparam int CTL_RX_EN = 4;
  // status field positions
  localparam int ST_TDRE = 7;
  localparam int ST_RDRF = 6;
  localparam int ST_OVR = 5;
  localparam int ST_FRM = 4;
  localparam int ST_PAR = 3;
  localparam int ST_TEND = 2;
  localparam int ST_MPBR = 1;
  localparam int ST_MPBT = 0;
  // event bits of the interrupt status register
  localparam int EV_NUM = 4;
  localparam int EV_TX_EMPTY = 0;
  localparam int EV_RX_FULL = 1;
  localparam int EV_RX_ERR = 2;
  localparam int EV_TX_END = 3;
  // ==========================================================
  // timing: bit time is (setting+1) * OVERSAMPLE clock cycles
  localparam int OVERSAMPLE = 16;
  localparam logic [3:0] MID_SAMPLE = 4'h7;
  // ==========================================================
  // types
  typedef enum logic [2:0] {
    TX_IDLE = 3'b001,
    TX_SHIFT = 3'b010,
    TX_STOP = 3'b100
  } scsd_tx_state_t;
  typedef enum logic [2:0] {
    RX_IDLE = 3'b001,
    RX_SHIFT = 3'b010,
    RX_STOP = 3'b100
  } scsd_rx_state_t;
  typedef struct packed {
    logic [31:0] addr;
    logic write;
    logic sel;
  } scsd_bus_req_t;
endpackage

// ==== verilog/scsd_rx.sv ====
/*
 receive shifter: start bit, 8 data bits lsb first, multiprocessor bit, stop.
 assumes rxd already passed two flip-flops and tick is a 16x bit-rate enable.
*/
`timescale 1ns/1ps
module scsd_rx (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // control
  input wire logic enable,
  input wire logic tick,
  input wire logic rxd_sync,
  // result
  output logic done,
  output logic [7:0] data,
  output logic mp_bit,
  output logic stop_ok
);
  // ==========================================================
  // state
  scsd_pkg::scsd_rx_state_t st_q, st_d;
  logic [3:0] os_q, os_d;      // oversample phase
  logic [3:0] bit_q, bit_d;    // bits taken so far
  logic [8:0] sh_q, sh_d;      // rx_shift_register plus mp bit
  logic done_q, done_d;
  logic ok_q, ok_d;

  // next state
  always_comb begin
    st_d = st_q;
    os_d = os_q;
    bit_d = bit_q;
    sh_d = sh_q;
    done_d = 1'b0;
    ok_d = ok_q;
    if (!enable) begin
      st_d = scsd_pkg::RX_IDLE;
    end else if (tick) begin
      os_d = os_q + 4'h1;
      case (st_q)
        scsd_pkg::RX_IDLE: begin
          // wait for a low start level, then realign phase
          if (!rxd_sync) begin
            st_d = scsd_pkg::RX_SHIFT;
            os_d = 4'h0;
            bit_d = 4'h0;
          end
        end
        scsd_pkg::RX_SHIFT: begin
          if (os_q == scsd_pkg::MID_SAMPLE) begin
            // first mid-sample is the start bit itself
            if (bit_q != 4'h0) begin
              sh_d = {rxd_sync, sh_q[8:1]};
            end
            bit_d = bit_q + 4'h1;
            if (bit_q == 4'h9) begin
              st_d = scsd_pkg::RX_STOP;
            end
            // line back high at the start mid-sample: a glitch or the tail
            // of a low stop bit, so drop it rather than shift in idle ones
            if (bit_q == 4'h0 && rxd_sync) begin
              st_d = scsd_pkg::RX_IDLE;
            end
          end
        end
        scsd_pkg::RX_STOP: begin
          if (os_q == scsd_pkg::MID_SAMPLE) begin
            ok_d = rxd_sync;
            done_d = 1'b1;
            st_d = scsd_pkg::RX_IDLE;
          end
        end
        default: st_d = scsd_pkg::RX_IDLE;
      endcase
    end
  end

  // registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      st_q <= scsd_pkg::RX_IDLE;
      os_q <= 4'h0;
      bit_q <= 4'h0;
      sh_q <= 9'h000;
      done_q <= 1'b0;
      ok_q <= 1'b0;
    end else begin
      st_q <= st_d;
      os_q <= os_d;
      bit_q <= bit_d;
      sh_q <= sh_d;
      done_q <= done_d;
      ok_q <= ok_d;
    end
  end

  assign done = done_q;
  assign data = sh_q[7:0];
  assign mp_bit = sh_q[8];
  assign stop_ok = ok_q;
endmodule

// ==== verilog/scsd_top.sv ====
/*
 serial channel: ahb-lite register slave, transmitter, receiver and interrupt.
 assumes one 25 MHz clock, single-word ahb-lite transfers, async rxd pin.
*/
// The AHB-Lite register port was decided locally.
// Contract
// - tdre zero write after read clears tend
// - writing transmit data clears tend
// - clearing transmit enable sets tend
// - tend reads zero while shifting out
// - mp received flag mirrors last mp bit
// - rdrf, ovr, frm and par flags cleared only by written zero
// - transmit data moves into shift register
// - eight bit rate setting, resets all ones
`timescale 1ns/1ps
module scsd_top (
  // clock and reset
  input wire logic clk,
  input wire logic rst_n,
  // ahb-lite slave
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  // serial pins
  output logic txd,
  output logic txd_oe,
  input wire logic rxd,
  // general i/o use of the pins while disabled
  input wire logic txd_gpio_out,
  output logic rxd_gpio_in,
  // interrupt
  output logic irq
);
  // ==========================================================
  // bus address phase capture
  scsd_pkg::scsd_bus_req_t req_q, req_d;
  logic [7:0] idx;
  logic wr_en, rd_en;
  // registers
  logic [7:0] tdr_q, tdr_d, rdr_q, rdr_d, brr_q, brr_d, ctl_q, ctl_d;
  logic [7:0] ssr_q, ssr_d;
  logic [7:0] wdat;
  logic tdre_seen_q, tdre_seen_d;   // tdre read as one since last clear
  logic [scsd_pkg::EV_NUM-1:0] ev_q, ev_d, en_q, en_d, ev_set;
  // divider
  logic [7:0] div_q, div_d;
  logic tick;
  logic [3:0] tx_os_q, tx_os_d;
  // transmitter
  scsd_pkg::scsd_tx_state_t tx_q, tx_d;
  logic [9:0] tx_shift_q, tx_shift_d;   // tx_shift_register: data + mp + stop
  logic [3:0] tx_cnt_q, tx_cnt_d;
  logic txd_q, txd_d;
  logic tx_last;
  // rx sync and receiver
  logic rxd_m_q, rxd_s_q;
  logic rx_done, rx_mp, rx_ok;
  logic [7:0] rx_data;
  logic [31:0] rdata_q, rdata_d;

  assign idx = req_q.addr[9:2];
  assign wr_en = req_q.sel && req_q.write;
  assign rd_en = hsel && hready && htrans[1] && !hwrite;
  assign wdat = hwdata[7:0];
  assign hreadyout = 1'b1;   // zero wait states
  assign hresp = 1'b0;       // always okay

  // ==========================================================
  // address phase next value
  always_comb begin
    req_d.addr = haddr;
    req_d.write = hwrite;
    req_d.sel = hsel && hready && htrans[1];
  end

  // ==========================================================
  // read data: computed in the address phase, held in a flop
  always_comb begin
    rdata_d = rdata_q;
    if (rd_en) begin
      rdata_d = 32'h0000_0000;   // unmapped reads zero
      case (haddr[9:2])
        scsd_pkg::IDX_TX_DATA: rdata_d[7:0] = tdr_q;
        scsd_pkg::IDX_RX_DATA: rdata_d[7:0] = rdr_q;
        scsd_pkg::IDX_BIT_RATE: rdata_d[7:0] = brr_q;
        scsd_pkg::IDX_CONTROL: rdata_d[7:0] = ctl_q;
        scsd_pkg::IDX_STATUS: rdata_d[7:0] = ssr_q;
        scsd_pkg::IDX_IRQ_STAT: rdata_d[scsd_pkg::EV_NUM-1:0] = ev_q;
        scsd_pkg::IDX_IRQ_EN: rdata_d[scsd_pkg::EV_NUM-1:0] = en_q;
        default: rdata_d = 32'h0000_0000;
      endcase
    end
  end
  assign hrdata = rdata_q;

  // ==========================================================
  // bit-rate divider: one tick per (setting+1) clocks, 16 ticks a bit
  always_comb begin
    div_d = div_q - 8'h01;
    tick = 1'b0;
    if (div_q == 8'h00) begin
      div_d = brr_q;
      tick = 1'b1;
    end
  end

  // ==========================================================
  // transmitter: loads the shift register from tdr when tdre is clear
  always_comb begin
    tx_d = tx_q;
    tx_shift_d = tx_shift_q;
    tx_cnt_d = tx_cnt_q;
    tx_os_d = tx_os_q;
    txd_d = txd_q;
    tx_last = 1'b0;
    if (!ctl_q[scsd_pkg::CTL_TX_EN]) begin
      tx_d = scsd_pkg::TX_IDLE;
      txd_d = 1'b1;
    end else if (tick) begin
      tx_os_d = tx_os_q + 4'h1;
      case (tx_q)
        scsd_pkg::TX_IDLE: begin
          if (!ssr_q[scsd_pkg::ST_TDRE]) begin
            tx_shift_d = {1'b1, ssr_q[scsd_pkg::ST_MPBT], tdr_q};
            txd_d = 1'b0;   // start bit
            tx_cnt_d = 4'h0;
            tx_os_d = 4'h0;
            tx_d = scsd_pkg::TX_SHIFT;
          end
        end
        scsd_pkg::TX_SHIFT: begin
          if (tx_os_q == 4'hf) begin
            txd_d = tx_shift_q[0];
            tx_shift_d = {1'b1, tx_shift_q[9:1]};
            tx_cnt_d = tx_cnt_q + 4'h1;
            if (tx_cnt_q == 4'h9) begin
              tx_d = scsd_pkg::TX_STOP;
            end
          end
        end
        scsd_pkg::TX_STOP: begin
          // stop bit on the line for one full bit time
          if (tx_os_q == 4'hf) begin
            tx_last = 1'b1;
            tx_d = scsd_pkg::TX_IDLE;
          end
        end
        default: tx_d = scsd_pkg::TX_IDLE;
      endcase
    end
  end

  // ==========================================================
  // register file and status flags; hardware set wins over clear
  always_comb begin
    tdr_d = tdr_q;
    rdr_d = rdr_q;
    brr_d = brr_q;
    ctl_d = ctl_q;
    ssr_d = ssr_q;
    en_d = en_q;
    tdre_seen_d = tdre_seen_q;
    ev_set = '0;
    // status read remembers tdre seen as one
    if (rd_en && haddr[9:2] == scsd_pkg::IDX_STATUS && ssr_q[scsd_pkg::ST_TDRE]) begin
      tdre_seen_d = 1'b1;
    end
    if (wr_en) begin
      case (idx)
        scsd_pkg::IDX_TX_DATA: begin
          tdr_d = wdat;
          ssr_d[scsd_pkg::ST_TDRE] = 1'b0;
          ssr_d[scsd_pkg::ST_TEND] = 1'b0;
        end
        scsd_pkg::IDX_BIT_RATE: brr_d = wdat;
        scsd_pkg::IDX_CONTROL: ctl_d = wdat;
        scsd_pkg::IDX_STATUS: begin
          // only a written zero clears; a one leaves the flag
          if (!wdat[scsd_pkg::ST_TDRE] && tdre_seen_q) begin
            ssr_d[scsd_pkg::ST_TDRE] = 1'b0;
            ssr_d[scsd_pkg::ST_TEND] = 1'b0;
            tdre_seen_d = 1'b0;
          end
          for (int i = scsd_pkg::ST_PAR; i <= scsd_pkg::ST_RDRF; i++) begin
            if (!wdat[i]) begin
              ssr_d[i] = 1'b0;
            end
          end
          ssr_d[scsd_pkg::ST_MPBT] = wdat[scsd_pkg::ST_MPBT];
        end
        scsd_pkg::IDX_IRQ_EN: en_d = wdat[scsd_pkg::EV_NUM-1:0];
        default: ;
      endcase
    end
    // transmitter took the byte: data register empty again
    if (tx_q == scsd_pkg::TX_IDLE && tick && ctl_q[scsd_pkg::CTL_TX_EN]
        && !ssr_q[scsd_pkg::ST_TDRE]) begin
      ssr_d[scsd_pkg::ST_TDRE] = 1'b1;
      ssr_d[scsd_pkg::ST_TEND] = 1'b0;
      ev_set[scsd_pkg::EV_TX_EMPTY] = 1'b1;
    end
    if (tx_last && ssr_q[scsd_pkg::ST_TDRE]) begin
      ssr_d[scsd_pkg::ST_TEND] = 1'b1;
      ev_set[scsd_pkg::EV_TX_END] = 1'b1;
    end
    // transmit enable cleared: empty and ended
    if (!ctl_d[scsd_pkg::CTL_TX_EN] && ctl_q[scsd_pkg::CTL_TX_EN]) begin
      ssr_d[scsd_pkg::ST_TDRE] = 1'b1;
      ssr_d[scsd_pkg::ST_TEND] = 1'b1;
    end
    // receive completion
    if (rx_done) begin
      ssr_d[scsd_pkg::ST_MPBR] = rx_mp;
      if (ssr_q[scsd_pkg::ST_RDRF]) begin
        ssr_d[scsd_pkg::ST_OVR] = 1'b1;
        ev_set[scsd_pkg::EV_RX_ERR] = 1'b1;
      end else if (!rx_ok) begin
        ssr_d[scsd_pkg::ST_FRM] = 1'b1;
        ev_set[scsd_pkg::EV_RX_ERR] = 1'b1;
      end else begin
        rdr_d = rx_data;
        ssr_d[scsd_pkg::ST_RDRF] = 1'b1;
        ev_set[scsd_pkg::EV_RX_FULL] = 1'b1;
      end
    end
    // parity is not selectable here, so its flag is only cleared
    ssr_d[scsd_pkg::ST_PAR] = ssr_d[scsd_pkg::ST_PAR] & ssr_q[scsd_pkg::ST_PAR];
  end

  // interrupt events: set wins over write-one clear
  always_comb begin
    ev_d = ev_q;
    if (wr_en && idx == scsd_pkg::IDX_IRQ_CLR) begin
      ev_d = ev_q & ~wdat[scsd_pkg::EV_NUM-1:0];
    end
    ev_d = ev_d | ev_set;
  end
  assign irq = |(ev_q & en_q);

  // ==========================================================
  // all registers
  always_ff @(posedge clk or negedge rst_n) begin
    if (!rst_n) begin
      req_q <= '0;
      rdata_q <= 32'h0000_0000;
      tdr_q <= scsd_pkg::RST_TX_DATA;
      rdr_q <= scsd_pkg::RST_RX_DATA;
      brr_q <= scsd_pkg::RST_BIT_RATE;
      ctl_q <= scsd_pkg::RST_CONTROL;
      ssr_q <= scsd_pkg::RST_STATUS;
      tdre_seen_q <= 1'b0;
      ev_q <= '0;
      en_q <= '0;
      div_q <= 8'h00;
      tx_q <= scsd_pkg::TX_IDLE;
      tx_shift_q <= 10'h3ff;
      tx_cnt_q <= 4'h0;
      tx_os_q <= 4'h0;
      txd_q <= 1'b1;
      rxd_m_q <= 1'b1;
      rxd_s_q <= 1'b1;
    end else begin
      req_q <= req_d;
      rdata_q <= rdata_d;
      tdr_q <= tdr_d;
      rdr_q <= rdr_d;
      brr_q <= brr_d;
      ctl_q <= ctl_d;
      ssr_q <= ssr_d;
      tdre_seen_q <= tdre_seen_d;
      ev_q <= ev_d;
      en_q <= en_d;
      div_q <= div_d;
      tx_q <= tx_d;
      tx_shift_q <= tx_shift_d;
      tx_cnt_q <= tx_cnt_d;
      tx_os_q <= tx_os_d;
      txd_q <= txd_d;
      rxd_m_q <= rxd;
      rxd_s_q <= rxd_m_q;
    end
  end

  // pins: serial function when enabled, general i/o otherwise
  assign txd = ctl_q[scsd_pkg::CTL_TX_EN] ? txd_q : txd_gpio_out;
  assign txd_oe = 1'b1;
  assign rxd_gpio_in = rxd_s_q;

  // ==========================================================
  // receiver
  scsd_rx u_rx (
    .clk(clk),
    .rst_n(rst_n),
    .enable(ctl_q[scsd_pkg::CTL_RX_EN]),
    .tick(tick),
    .rxd_sync(rxd_s_q),
    .done(rx_done),
    .data(rx_data),
    .mp_bit(rx_mp),
    .stop_ok(rx_ok)
  );
endmodule
